// File: logic/bcd_params.svh
// Purpose: Constants for the branch decode and instruction timing block.
// Assumes: One core clock; four clocks to an instruction cycle.
// Notes: Opcode patterns with don't-care bits are written in binary.
`ifndef BCD_PARAMS_SVH
`define BCD_PARAMS_SVH

`define BCD_CLOCK_MHZ          100
`define BCD_PHASE_COUNT        4
`define BCD_PHASE_RST          4'h1
`define BCD_TIMER_SLOW_DIV     4'hC
`define BCD_TIMER_FAST_DIV     4'h4
`define BCD_STRETCH_RST        3'h1
`define BCD_PC_RST             16'h0000

`define BCD_OP_JUMP_IF_BIT_CLEAR       8'h30
`define BCD_OP_JUMP_IF_BIT_SET_CLEAR   8'h10
`define BCD_OP_JUMP_INDIRECT           8'h73
`define BCD_OP_JUMP_IF_ACC_ZERO        8'h60
`define BCD_OP_JUMP_IF_ACC_NONZERO     8'h70
`define BCD_OP_CMP_JUMP_DIRECT         8'hB5
`define BCD_OP_CMP_JUMP_IMM            8'hB4
`define BCD_OP_CMP_JUMP_REG            8'b1011_1???
`define BCD_OP_CMP_JUMP_IND            8'b1011_011?
`define BCD_OP_DEC_JUMP_REG            8'b1101_1???
`define BCD_OP_DEC_JUMP_DIRECT         8'hD5
`define BCD_OP_NO_OPERATION            8'h00
`define BCD_OP_NO_OPERATION_ALT        8'hA5
`define BCD_OP_EXT_MOVE_DATA_POINTER   8'b111?_0000
`define BCD_OP_EXT_MOVE_INDIRECT       8'b111?_001?
`define BCD_OP_MOVE_DIRECT_DIRECT      8'h85
`define BCD_OP_MULTIPLY                8'hA4
`define BCD_OP_DIVIDE                  8'h84

`define BCD_BYTES_1            3'h1
`define BCD_BYTES_2            3'h2
`define BCD_BYTES_3            3'h3
`define BCD_CYC_1              4'h1
`define BCD_CYC_3              4'h3
`define BCD_CYC_4              4'h4
`define BCD_CYC_EXT_MOVE_BASE  4'h2
`define BCD_CYC_MULDIV         4'h5

`endif

// File: logic/bcd_pkg.sv
// Purpose: Types shared by the branch decode and timing block and its bench.
// Assumes: Constants come from bcd_params.svh.
// Notes: Kind codes are plain binary; the sequencer states are one-hot.
package bcd_pkg;

  typedef enum logic [4:0] {
    BCD_K_OTHER        = 5'h00,
    BCD_K_NO_OPERATION = 5'h01,
    BCD_K_BIT_CLEAR    = 5'h02,
    BCD_K_BIT_SET_CLR  = 5'h03,
    BCD_K_JUMP_IND     = 5'h04,
    BCD_K_ACC_ZERO     = 5'h05,
    BCD_K_ACC_NONZERO  = 5'h06,
    BCD_K_CMP_DIRECT   = 5'h07,
    BCD_K_CMP_IMM      = 5'h08,
    BCD_K_CMP_REG      = 5'h09,
    BCD_K_CMP_IND      = 5'h0A,
    BCD_K_DEC_REG      = 5'h0B,
    BCD_K_DEC_DIRECT   = 5'h0C,
    BCD_K_EXT_MOVE     = 5'h0D,
    BCD_K_MOVE_DD      = 5'h0E,
    BCD_K_MULDIV       = 5'h0F
  } bcd_kind_t;

  typedef enum logic [2:0] {
    BCD_ST_OPCODE  = 3'b001,
    BCD_ST_OPERAND = 3'b010,
    BCD_ST_HOLD    = 3'b100
  } bcd_state_t;

  typedef struct packed {
    bcd_kind_t   kind;
    logic [2:0]  bytes;
    logic [3:0]  cycles;
  } bcd_dec_t;

  typedef struct packed {
    logic        en;
    logic        is_bit;
    logic        is_reg;
    logic [7:0]  addr;
    logic [7:0]  data;
  } bcd_wr_t;

  typedef struct packed {
    logic        valid;
    logic        taken;
    logic [15:0] next_pc;
  } bcd_exec_t;

endpackage

// File: logic/bcd_branch_timing.sv
// Purpose: Opcode decode for the branch and no-operation group and the four-phase
//          instruction cycle sequencer of a small 8-bit core.
// Assumes: Program memory returns the requested byte by the edge ending phase four.
// Notes: The datapath must forward a pending write to a following instruction.
// Operation
// - Opcode 30 branches relative when direct bit is zero; three bytes, four cycles.
// - Opcode 10 branches when bit is one and clears it; three bytes, four cycles.
// - Opcode 73 jumps to accumulator plus active data pointer; one byte, three cycles.
// - Opcodes 60 and 70 branch on accumulator zero or nonzero; two bytes, three cycles.
// - Opcodes B5 and B4 compare accumulator with direct or immediate, branch if unequal.
// - Opcodes B8-BF and B6-B7 compare register or indirect with immediate, branch if unequal.
// - Opcodes D8-DF and D5 decrement operand and branch when the result is nonzero.
// - Opcodes 00 and A5 are one-byte, one-cycle no-operations without any effect.
// - Every instruction cycle lasts exactly four core clocks.
// - Each instruction finishes within one to nine cycles per its opcode count.
// - External data move takes two cycles plus the stretch value; direct-to-direct move takes three.
// - One instruction cycle per byte fetched; multiply and divide take extra cycles.
// - Timers advance every twelve clocks, or every four when configured fast.
// - Each instruction cycle splits into four one-clock phases driving events.
// - Instruction n executes while instruction n+1 is being fetched.
// - The data write of instruction n happens during the fetch of n+2.
// - Level interrupts are sampled on the edge ending phase three.
// - External data moves stretch by a three-bit value resetting to one.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_params.svh"

module bcd_branch_timing (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic [7:0]        code_data_i,
  input  wire logic [7:0]        acc_i,
  input  wire logic [15:0]       data_pointer_i,
  input  wire logic              bit_val_i,
  input  wire logic [7:0]        dir_val_i,
  input  wire logic [7:0]        reg_val_i,
  input  wire logic              irq_level_i,
  input  wire logic              timer_fast_i,
  input  wire logic              stretch_wr_i,
  input  wire logic [2:0]        stretch_data_i,
  output logic      [3:0]        phase_o,
  output logic                   code_rd_o,
  output logic      [15:0]       code_addr_o,
  output logic      [7:0]        opcode_o,
  output logic      [7:0]        operand_addr_o,
  output logic      [2:0]        reg_sel_o,
  output logic                   reg_ind_o,
  output logic                   irq_sample_o,
  output logic                   timer_tick_o,
  output logic      [2:0]        stretch_o,
  output bcd_pkg::bcd_exec_t     exec_o,
  output bcd_pkg::bcd_wr_t       wr_o
);
  import bcd_pkg::*;

  logic [3:0]  phase_ff;
  bcd_state_t  st_ff;
  bcd_state_t  nxt_st;
  logic [3:0]  icyc_ff;
  logic [3:0]  nxt_icyc;
  logic [15:0] pc_ff;
  logic [15:0] pc_seq;
  logic [15:0] nxt_pc;
  logic [7:0]  opcode_ff;
  logic [7:0]  b1_ff;
  logic [7:0]  b2_ff;
  logic [2:0]  reg_sel_ff;
  logic        reg_ind_ff;
  logic        code_rd_ff;
  logic [15:0] code_addr_ff;
  logic        irq_ff;
  logic [3:0]  tdiv_ff;
  logic [3:0]  tdiv_lim;
  logic        tick_ff;
  logic [2:0]  stretch_ff;
  bcd_exec_t   exec_ff;
  bcd_wr_t     pend_wr_ff;
  bcd_wr_t     wr_ff;
  bcd_wr_t     wr_new;
  bcd_dec_t    dec;
  logic [7:0]  dec_op;
  logic        end_cyc;
  logic        fetch_now;
  logic        instr_end;
  logic        taken;
  logic [7:0]  rel;
  logic [7:0]  dec_val;
  logic [15:0] rel_target;
  logic [15:0] target;

  function automatic bcd_dec_t decode(input logic [7:0] op, input logic [2:0] st);
    bcd_dec_t d;
    d = '{BCD_K_OTHER, `BCD_BYTES_1, `BCD_CYC_1};
    casez (op)
      `BCD_OP_JUMP_IF_BIT_CLEAR:     d = '{BCD_K_BIT_CLEAR, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_JUMP_IF_BIT_SET_CLEAR: d = '{BCD_K_BIT_SET_CLR, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_JUMP_INDIRECT:         d = '{BCD_K_JUMP_IND, `BCD_BYTES_1, `BCD_CYC_3};
      `BCD_OP_JUMP_IF_ACC_ZERO:      d = '{BCD_K_ACC_ZERO, `BCD_BYTES_2, `BCD_CYC_3};
      `BCD_OP_JUMP_IF_ACC_NONZERO:   d = '{BCD_K_ACC_NONZERO, `BCD_BYTES_2, `BCD_CYC_3};
      `BCD_OP_CMP_JUMP_DIRECT:       d = '{BCD_K_CMP_DIRECT, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_CMP_JUMP_IMM:          d = '{BCD_K_CMP_IMM, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_CMP_JUMP_REG:          d = '{BCD_K_CMP_REG, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_CMP_JUMP_IND:          d = '{BCD_K_CMP_IND, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_DEC_JUMP_REG:          d = '{BCD_K_DEC_REG, `BCD_BYTES_2, `BCD_CYC_3};
      `BCD_OP_DEC_JUMP_DIRECT:       d = '{BCD_K_DEC_DIRECT, `BCD_BYTES_3, `BCD_CYC_4};
      `BCD_OP_NO_OPERATION,
      `BCD_OP_NO_OPERATION_ALT:      d = '{BCD_K_NO_OPERATION, `BCD_BYTES_1, `BCD_CYC_1};
      // external move base count; stretch added.
      `BCD_OP_EXT_MOVE_DATA_POINTER,
      `BCD_OP_EXT_MOVE_INDIRECT: begin
        d = '{BCD_K_EXT_MOVE, `BCD_BYTES_1, `BCD_CYC_EXT_MOVE_BASE + {1'b0, st}};
      end
      `BCD_OP_MOVE_DIRECT_DIRECT:    d = '{BCD_K_MOVE_DD, `BCD_BYTES_3, `BCD_CYC_3};
      // multiply and divide exceed their byte count.
      `BCD_OP_MULTIPLY, `BCD_OP_DIVIDE: d = '{BCD_K_MULDIV, `BCD_BYTES_1, `BCD_CYC_MULDIV};
      default:                       d.kind = BCD_K_OTHER;
    endcase
    return d;
  endfunction

  // one-hot phase ring, one clock per phase.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_ff <= `BCD_PHASE_RST;
    end else begin
      phase_ff <= {phase_ff[2:0], phase_ff[3]};
    end
  end

  // an instruction cycle ends with the fourth phase.
  assign end_cyc   = phase_ff[3];
  assign fetch_now = (st_ff != BCD_ST_HOLD);
  // The opcode is only in a register after the first cycle, so decode the bus then.
  assign dec_op    = (st_ff == BCD_ST_OPCODE) ? code_data_i : opcode_ff;
  assign dec       = decode(dec_op, stretch_ff);
  assign nxt_icyc  = icyc_ff + 4'h1;
  // completion follows the opcode's own cycle count.
  assign instr_end = end_cyc && (nxt_icyc == dec.cycles);
  // the address advances once per fetched byte.
  assign pc_seq    = pc_ff + {15'h0000, fetch_now};
  assign rel       = (dec.bytes == `BCD_BYTES_3) ? b2_ff : b1_ff;
  // signed offset from the following instruction.
  assign rel_target = pc_seq + {{8{rel[7]}}, rel};

  always_comb begin
    taken   = 1'b0;
    target  = rel_target;
    dec_val = 8'h00;
    wr_new  = '0;
    case (dec.kind)
      BCD_K_BIT_CLEAR: taken = !bit_val_i;
      // taken on a one bit, which is then cleared.
      BCD_K_BIT_SET_CLR: begin
        taken  = bit_val_i;
        wr_new = '{bit_val_i, 1'b1, 1'b0, b1_ff, 8'h00};
      end
      // indirect target from accumulator and pointer.
      BCD_K_JUMP_IND: begin
        taken  = 1'b1;
        target = data_pointer_i + {8'h00, acc_i};
      end
      BCD_K_ACC_ZERO:    taken = (acc_i == 8'h00);
      BCD_K_ACC_NONZERO: taken = (acc_i != 8'h00);
      BCD_K_CMP_DIRECT: taken = (acc_i != dir_val_i);
      BCD_K_CMP_IMM:    taken = (acc_i != b1_ff);
      BCD_K_CMP_REG, BCD_K_CMP_IND: taken = (reg_val_i != b1_ff);
      BCD_K_DEC_REG: begin
        dec_val = reg_val_i - 8'h01;
        taken   = (dec_val != 8'h00);
        wr_new  = '{1'b1, 1'b0, 1'b1, {5'h00, reg_sel_ff}, dec_val};
      end
      BCD_K_DEC_DIRECT: begin
        dec_val = dir_val_i - 8'h01;
        taken   = (dec_val != 8'h00);
        wr_new  = '{1'b1, 1'b0, 1'b0, b1_ff, dec_val};
      end
      default: taken = 1'b0;
    endcase
  end

  // the branch resolves only at the last listed cycle, taken or not.
  assign nxt_pc = (instr_end && taken) ? target : pc_seq;

  always_comb begin
    if (instr_end) begin
      nxt_st = BCD_ST_OPCODE;
    end else if ({1'b0, nxt_icyc} < {2'b00, dec.bytes}) begin
      nxt_st = BCD_ST_OPERAND;
    end else begin
      nxt_st = BCD_ST_HOLD;
    end
  end

  // sequencer steps once per instruction cycle.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff   <= BCD_ST_OPCODE;
      icyc_ff <= 4'h0;
      pc_ff   <= `BCD_PC_RST;
    end else if (end_cyc) begin
      st_ff   <= nxt_st;
      icyc_ff <= instr_end ? 4'h0 : nxt_icyc;
      pc_ff   <= nxt_pc;
    end
  end

  // capture one byte per fetching instruction cycle.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opcode_ff  <= 8'h00;
      b1_ff      <= 8'h00;
      b2_ff      <= 8'h00;
      reg_sel_ff <= 3'h0;
      reg_ind_ff <= 1'b0;
    end else if (end_cyc && fetch_now) begin
      case (icyc_ff)
        4'h0: begin
          opcode_ff  <= code_data_i;
          // low opcode bits pick the working or pointer register.
          reg_sel_ff <= code_data_i[3] ? code_data_i[2:0] : {2'b00, code_data_i[0]};
          reg_ind_ff <= !code_data_i[3];
        end
        4'h1: begin
          b1_ff <= code_data_i;
        end
        default: begin
          b2_ff <= code_data_i;
        end
      endcase
    end
  end

  // the fetch strobe is a phase one event.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_rd_ff   <= 1'b1;
      code_addr_ff <= `BCD_PC_RST;
    end else if (end_cyc) begin
      code_rd_ff   <= (nxt_st != BCD_ST_HOLD);
      code_addr_ff <= nxt_pc;
    end else begin
      code_rd_ff   <= 1'b0;
    end
  end

  // results of n are flagged valid for one clock, phase one of the first cycle of n+1.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exec_ff <= '0;
    end else if (instr_end) begin
      exec_ff <= '{1'b1, taken, nxt_pc};
    end else begin
      exec_ff.valid <= 1'b0;
    end
  end

  // a write waits one instruction boundary, then pulses as n+2 is fetched.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_wr_ff <= '0;
      wr_ff      <= '0;
    end else if (instr_end) begin
      pend_wr_ff <= wr_new;
      wr_ff      <= pend_wr_ff;
    end else begin
      wr_ff.en   <= 1'b0;
    end
  end

  // sampled on the edge that closes phase three.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_ff <= 1'b0;
    end else if (phase_ff[2]) begin
      irq_ff <= irq_level_i;
    end
  end

  // prescale of twelve, or four in fast mode.
  assign tdiv_lim = timer_fast_i ? (`BCD_TIMER_FAST_DIV - 4'h1) : (`BCD_TIMER_SLOW_DIV - 4'h1);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdiv_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else if (tdiv_ff >= tdiv_lim) begin
      tdiv_ff <= 4'h0;
      tick_ff <= 1'b1;
    end else begin
      tdiv_ff <= tdiv_ff + 4'h1;
      tick_ff <= 1'b0;
    end
  end

  // stretch value, changeable at any time, resets to one.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stretch_ff <= `BCD_STRETCH_RST;
    end else if (stretch_wr_i) begin
      stretch_ff <= stretch_data_i;
    end
  end

  assign phase_o        = phase_ff;
  assign code_rd_o      = code_rd_ff;
  assign code_addr_o    = code_addr_ff;
  assign opcode_o       = opcode_ff;
  assign operand_addr_o = b1_ff;
  assign reg_sel_o      = reg_sel_ff;
  assign reg_ind_o      = reg_ind_ff;
  assign irq_sample_o   = irq_ff;
  assign timer_tick_o   = tick_ff;
  assign stretch_o      = stretch_ff;
  assign exec_o         = exec_ff;
  assign wr_o           = wr_ff;

endmodule // bcd_branch_timing

`default_nettype wire

// File: testbench/bcd_code_mem.sv
// Purpose: Program memory model that answers the fetch port of the block.
// Assumes: A byte is wanted from the phase one strobe to the edge that ends phase four.
// Notes: The bench loads the array through a hierarchical reference.
`timescale 1ns/1ps
`default_nettype none

module bcd_code_mem (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        code_rd_i,
  input  wire logic [3:0]  phase_i,
  input  wire logic [15:0] code_addr_i,
  output logic      [7:0]  code_data_o
);
  logic [7:0] mem [0:65535];
  logic       live_ff;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      live_ff <= 1'b0;
    end else if (code_rd_i) begin
      live_ff <= 1'b1;
    end else if (phase_i[3]) begin
      live_ff <= 1'b0;
    end
  end

  // Outside a fetch the bus shows the inverse, so a late sample never looks right.
  assign code_data_o = live_ff ? mem[code_addr_i] : ~mem[code_addr_i];
endmodule // bcd_code_mem

`default_nettype wire

// File: testbench/bcd_chk.sv
// Purpose: Port checker for the branch decode and timing block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none

module bcd_chk (
  input wire logic               clock_i,
  input wire logic               rstn_i,
  input wire logic               irq_level_i,
  input wire logic               timer_fast_i,
  input wire logic               stretch_wr_i,
  input wire logic [2:0]         stretch_data_i,
  input wire logic [3:0]         phase_o,
  input wire logic               code_rd_o,
  input wire logic [15:0]        code_addr_o,
  input wire logic               irq_sample_o,
  input wire logic               timer_tick_o,
  input wire logic [2:0]         stretch_o,
  input wire bcd_pkg::bcd_exec_t exec_o,
  input wire bcd_pkg::bcd_wr_t   wr_o
);
  import bcd_pkg::*;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_phase_walk;
    phase_o[1] ##1 phase_o[2] ##1 phase_o[3] ##1 phase_o[0];
  endsequence

  sequence s_slow_run;
    (timer_tick_o && !timer_fast_i) ##1 !timer_fast_i[*8] ##1 !timer_fast_i[*3];
  endsequence

  a_phase_ring_walk: assert property (phase_o == 4'h1 |=> s_phase_walk)
    else $error("phase ring broken");
  a_fetch_phase_one: assert property (code_rd_o |-> phase_o == 4'h1)
    else $error("fetch strobe outside phase one");
  a_fetch_addr_steady: assert property (phase_o != 4'h1 |-> $stable(code_addr_o))
    else $error("fetch address moved mid cycle");
  a_exec_at_boundary: assert property (exec_o.valid |-> phase_o == 4'h1 ##1 !exec_o.valid)
    else $error("execute result off boundary");
  a_write_slot_pulse: assert property (wr_o.en |-> phase_o == 4'h1 ##1 !wr_o.en)
    else $error("write outside its slot");
  a_irq_capture_edge: assert property (phase_o[2] |=> irq_sample_o == $past(irq_level_i))
    else $error("interrupt not captured");
  a_irq_hold_else: assert property (!phase_o[2] |=> $stable(irq_sample_o))
    else $error("interrupt sample moved");
  a_tick_quiet_gap: assert property (timer_tick_o |=> !timer_tick_o[*3])
    else $error("timer ticks too close");
  a_tick_fast_rate: assert property ((timer_tick_o && timer_fast_i) ##1 timer_fast_i[*3]
    |=> timer_tick_o)
    else $error("fast tick late");
  a_tick_slow_rate: assert property (s_slow_run |=> timer_tick_o)
    else $error("slow tick late");
  a_stretch_load: assert property (stretch_wr_i |=> stretch_o == $past(stretch_data_i))
    else $error("stretch not loaded");
endmodule // bcd_chk

bind bcd_branch_timing bcd_chk bcd_chk_i (
  .clock_i, .rstn_i, .irq_level_i, .timer_fast_i, .stretch_wr_i, .stretch_data_i,
  .phase_o, .code_rd_o, .code_addr_o, .irq_sample_o, .timer_tick_o, .stretch_o,
  .exec_o, .wr_o
);

`default_nettype wire

// File: testbench/bcd_branch_timing_bench.sv
// Purpose: Self-checking bench for the branch decode and timing block.
// Assumes: Each case runs from reset at address zero, followed by no-operations.
// Notes: Inputs change at the falling edge only.
`timescale 1ns/1ps
`default_nettype none

module bcd_branch_timing_bench;
  import bcd_pkg::*;

  logic        clock_i        = 1'b0;
  logic        rstn_i         = 1'b0;
  logic [7:0]  code_data_i;
  logic [7:0]  acc_i          = 8'h00;
  logic [15:0] data_pointer_i = 16'h0000;
  logic        bit_val_i      = 1'b0;
  logic [7:0]  dir_val_i      = 8'h00;
  logic [7:0]  reg_val_i      = 8'h00;
  logic        irq_level_i    = 1'b0;
  logic        timer_fast_i   = 1'b0;
  logic        stretch_wr_i   = 1'b0;
  logic [2:0]  stretch_data_i = 3'h0;
  logic [3:0]  phase_o;
  logic        code_rd_o;
  logic [15:0] code_addr_o;
  logic [7:0]  opcode_o;
  logic [7:0]  operand_addr_o;
  logic [2:0]  reg_sel_o;
  logic        reg_ind_o;
  logic        irq_sample_o;
  logic        timer_tick_o;
  logic [2:0]  stretch_o;
  bcd_exec_t   exec_o;
  bcd_wr_t     wr_o;
  logic [2:0]  sel_seen;
  logic        ind_seen;
  logic        st_load        = 1'b0;
  logic [2:0]  st_val         = 3'h0;
  int          failures       = 0;
  int          n_checks       = 0;

  always #5 clock_i = ~clock_i;

  bcd_branch_timing bcd_branch_timing_i (
    .clock_i, .rstn_i, .code_data_i, .acc_i, .data_pointer_i, .bit_val_i, .dir_val_i,
    .reg_val_i, .irq_level_i, .timer_fast_i, .stretch_wr_i, .stretch_data_i, .phase_o,
    .code_rd_o, .code_addr_o, .opcode_o, .operand_addr_o, .reg_sel_o, .reg_ind_o,
    .irq_sample_o, .timer_tick_o, .stretch_o, .exec_o, .wr_o
  );

  bcd_code_mem bcd_code_mem_i (
    .clock_i, .rstn_i, .code_rd_i(code_rd_o), .phase_i(phase_o),
    .code_addr_i(code_addr_o), .code_data_o(code_data_i)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Runs one instruction from reset and judges its length, outcome and write slot.
  task automatic run_one(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                         input int cyc, input logic tk, input logic [15:0] pc,
                         input bcd_wr_t w);
    int n;
    rstn_i = 1'b0;
    for (n = 0; n < 65536; n++) begin
      bcd_code_mem_i.mem[n] = 8'h00;
    end
    bcd_code_mem_i.mem[0] = b0;
    bcd_code_mem_i.mem[1] = b1;
    bcd_code_mem_i.mem[2] = b2;
    repeat (3) @(negedge clock_i);
    rstn_i = 1'b1;
    n = 0;
    if (st_load) begin
      stretch_data_i = st_val;
      stretch_wr_i = 1'b1;
    end
    do begin
      @(negedge clock_i);
      stretch_wr_i = 1'b0;
      n++;
      if (exec_o.valid !== 1'b1) begin
        sel_seen = reg_sel_o;
        ind_seen = reg_ind_o;
      end
    end while (exec_o.valid !== 1'b1 && n < 60);
    chk(n, 4 * cyc, "clock count");
    chk(exec_o.taken, tk, "taken");
    chk(exec_o.next_pc, pc, "next address");
    chk(opcode_o, b0, "opcode");
    repeat (3) begin
      @(negedge clock_i);
      chk(wr_o.en, 1'b0, "early write");
    end
    @(negedge clock_i);
    if (w.en) begin
      chk(wr_o, w, "write back");
    end else begin
      chk(wr_o.en, 1'b0, "spurious write");
    end
  endtask

  task automatic t_reset();
    @(negedge clock_i);
    chk(phase_o, 4'h1, "reset phase");
    chk(stretch_o, 3'h1, "reset stretch");
    $display("t_reset done");
  endtask

  task automatic t_nop();
    run_one(8'h00, 8'h00, 8'h00, 1, 1'b0, 16'h0001, '0);
    run_one(8'hA5, 8'h00, 8'h00, 1, 1'b0, 16'h0001, '0);
    $display("t_nop done");
  endtask

  task automatic t_bit();
    bit_val_i = 1'b0;
    run_one(8'h30, 8'h20, 8'h10, 4, 1'b1, 16'h0013, '0);
    run_one(8'h10, 8'h20, 8'h04, 4, 1'b0, 16'h0003, '0);
    bit_val_i = 1'b1;
    run_one(8'h30, 8'h20, 8'h10, 4, 1'b0, 16'h0003, '0);
    run_one(8'h10, 8'h20, 8'h04, 4, 1'b1, 16'h0007, '{1'b1, 1'b1, 1'b0, 8'h20, 8'h00});
    chk(operand_addr_o, 8'h20, "bit address");
    $display("t_bit done");
  endtask

  task automatic t_acc();
    acc_i = 8'h05;
    data_pointer_i = 16'h1234;
    run_one(8'h73, 8'h00, 8'h00, 3, 1'b1, 16'h1239, '0);
    acc_i = 8'h00;
    run_one(8'h60, 8'hFB, 8'h00, 3, 1'b1, 16'hFFFD, '0);
    run_one(8'h70, 8'h05, 8'h00, 3, 1'b0, 16'h0002, '0);
    acc_i = 8'h80;
    run_one(8'h70, 8'h05, 8'h00, 3, 1'b1, 16'h0007, '0);
    $display("t_acc done");
  endtask

  task automatic t_compare();
    acc_i = 8'h12;
    dir_val_i = 8'h13;
    run_one(8'hB5, 8'h40, 8'h04, 4, 1'b1, 16'h0007, '0);
    run_one(8'hB4, 8'h12, 8'h04, 4, 1'b0, 16'h0003, '0);
    reg_val_i = 8'h07;
    for (int j = 8'hB6; j <= 8'hBF; j++) begin
      run_one(8'(j), 8'h08, 8'h04, 4, 1'b1, 16'h0007, '0);
      chk(sel_seen, j[3] ? j[2:0] : {2'b00, j[0]}, "register select");
      chk(ind_seen, !j[3], "indirect select");
    end
    run_one(8'hB8, 8'h07, 8'h04, 4, 1'b0, 16'h0003, '0);
    $display("t_compare done");
  endtask

  task automatic t_decrement();
    reg_val_i = 8'h02;
    for (int j = 8'hD8; j <= 8'hDF; j++) begin
      run_one(8'(j), 8'h04, 8'h00, 3, 1'b1, 16'h0006, '{1'b1, 1'b0, 1'b1, {5'h00, j[2:0]}, 8'h01});
    end
    reg_val_i = 8'h01;
    run_one(8'hD8, 8'h04, 8'h00, 3, 1'b0, 16'h0002, '{1'b1, 1'b0, 1'b1, 8'h00, 8'h00});
    dir_val_i = 8'h01;
    run_one(8'hD5, 8'h40, 8'h04, 4, 1'b0, 16'h0003, '{1'b1, 1'b0, 1'b0, 8'h40, 8'h00});
    $display("t_decrement done");
  endtask

  task automatic t_timing();
    run_one(8'h85, 8'h30, 8'h31, 3, 1'b0, 16'h0003, '0);
    run_one(8'hA4, 8'h00, 8'h00, 5, 1'b0, 16'h0001, '0);
    run_one(8'h84, 8'h00, 8'h00, 5, 1'b0, 16'h0001, '0);
    run_one(8'hE0, 8'h00, 8'h00, 3, 1'b0, 16'h0001, '0);
    st_load = 1'b1;
    st_val = 3'h0;
    run_one(8'hE0, 8'h00, 8'h00, 2, 1'b0, 16'h0001, '0);
    run_one(8'hF2, 8'h00, 8'h00, 2, 1'b0, 16'h0001, '0);
    st_val = 3'h7;
    run_one(8'hE0, 8'h00, 8'h00, 9, 1'b0, 16'h0001, '0);
    st_load = 1'b0;
    $display("t_timing done");
  endtask

  task automatic t_irq_timer();
    int n;
    for (int j = 0; j < 2; j++) begin
      timer_fast_i = (j == 0);
      run_one(8'h00, 8'h00, 8'h00, 1, 1'b0, 16'h0001, '0);
      n = 0;
      while (timer_tick_o !== 1'b1 && n < 16) begin
        @(negedge clock_i);
        n++;
      end
      n = 0;
      do begin
        @(negedge clock_i);
        n++;
      end while (timer_tick_o !== 1'b1 && n < 16);
      chk(n, (j == 0) ? 4 : 12, "tick spacing");
    end
    n = 0;
    while (phase_o !== 4'h4 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    chk(phase_o, 4'h4, "phase three");
    irq_level_i = 1'b1;
    @(negedge clock_i);
    chk(irq_sample_o, 1'b1, "irq capture");
    irq_level_i = 1'b0;
    @(negedge clock_i);
    chk(irq_sample_o, 1'b1, "irq hold");
    $display("t_irq_timer done");
  endtask

  initial begin
    t_reset();
    t_nop();
    t_bit();
    t_acc();
    t_compare();
    t_decrement();
    t_timing();
    t_irq_timer();
    end_of_test();
  end

  // The full sequence needs some 900 clocks; this leaves ample margin.
  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // bcd_branch_timing_bench

`default_nettype wire
